// ===== src/slf_formatter.sv
// sensor log record formatter with its word fifo
module slf_fifo
  import slf_pkg::*;
#(
  parameter int WIDTH = SLF_WORD_W,
  parameter int DEPTH = SLF_FIFO_DEPTH
) (
  input  wire logic                       i_mclk,
  input  wire logic                       i_nrst,
  input  wire logic                       i_in_valid,
  input  wire logic [WIDTH-1:0]           i_in_data,
  output logic                            o_in_ready,
  output logic                            o_out_valid,
  output logic [WIDTH-1:0]                o_out_data,
  input  wire logic                       i_out_ready,
  output logic [$clog2(DEPTH):0]          o_level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp;
  logic [AW:0]      rp;
  wire              full  = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  wire              empty = (wp == rp);
  wire              push  = i_in_valid && !full;
  wire              pop   = i_out_ready && !empty;

  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem[rp[AW-1:0]];
  assign o_level     = wp - rp;

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wp[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
    end
  end
endmodule : slf_fifo

// Contract
// - three-bit mode field picks storage format
// - mode 000 stores every value, no time
// - mode 001 stores out-of-limit values with number
// - mode 011 stores only limit crossings with number
// - limits checked only on selected sensor
// - modes 101/110/111 log on external interrupts
// - temperature-only dense packs eight results per five words
// - battery word: six-bit battery, ten-bit temperature
// - one external: range/value word before battery word
// - two externals: sensor one, two, then battery
// - both limit modes: sensor words then number
// - interrupt records end with clock high, low
// - interrupt modes ignore the limits
module slf_formatter
  import slf_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire slf_sample_t i_meas,
  input  wire logic        i_meas_valid,
  output logic             o_meas_ready,
  input  wire logic        i_external_sensor_one_input,
  input  wire logic        i_external_sensor_two_input,
  output logic      [15:0] o_word,
  output logic             o_word_valid,
  input  wire logic        i_word_ready
);
  slf_cfg_t    cfg;
  slf_cfg_t    rec_cfg;
  logic [9:0]  lim_lo;
  logic [9:0]  lim_hi;
  slf_sample_t rec;
  logic [15:0] meas_cnt;
  logic [15:0] rec_num;
  slf_state_t  state;
  slf_state_t  next_state;
  logic [2:0]  idx;
  logic [2:0]  nwords;
  logic [31:0] acc;
  logic [4:0]  nbits;
  logic [1:0]  zone;
  logic [1:0]  irq_s1;
  logic [1:0]  irq_s2;
  logic [1:0]  irq_s3;
  logic [1:0]  pend;
  // register decode
  wire cfg_wr    = i_wr && (i_addr == SLF_ADDR_CFG);
  wire lo_wr     = i_wr && (i_addr == SLF_ADDR_LIM_LO);
  wire hi_wr     = i_wr && (i_addr == SLF_ADDR_LIM_HI);
  // sample decisions taken on the live input at acceptance
  wire accept    = i_meas_valid && o_meas_ready;
  wire is_dense  = (cfg.mode == SLF_MODE_DENSE);
  wire is_limit  = (cfg.mode == SLF_MODE_OUT) || (cfg.mode == SLF_MODE_CROSS);
  wire temp_only = is_dense && !cfg.batt_en && (cfg.ext_en == 2'h0);

  logic [9:0] sel_val;
  always_comb begin
    unique case (cfg.limit_check_sensor_select)
      SLF_SEL_TEMP: sel_val = i_meas.temp;
      SLF_SEL_EXTERNAL_SENSOR_ONE_INPUT: sel_val = i_meas.external_sensor_one_input_val;
      SLF_SEL_EXTERNAL_SENSOR_TWO_INPUT: sel_val = i_meas.external_sensor_two_input_val;
      SLF_SEL_BATT: sel_val = {4'h0, i_meas.batt};
    endcase
  end

  wire       below    = sel_val < lim_lo;
  wire       above    = sel_val > lim_hi;
  wire [1:0] new_zone = below ? SLF_ZONE_BELOW : (above ? SLF_ZONE_ABOVE : SLF_ZONE_IN);

  // interrupt sources enabled by the mode; the limits play no part here
  wire [1:0] irq_mask = (cfg.mode == SLF_MODE_IRQ1)  ? 2'h1 :
                        (cfg.mode == SLF_MODE_IRQ2)  ? 2'h2 :
                        (cfg.mode == SLF_MODE_IRQ12) ? 2'h3 : 2'h0;
  wire       irq_hit  = |(pend & irq_mask);
  wire [1:0] irq_rise = irq_s2 & ~irq_s3;

  logic store;
  always_comb begin
    unique case (cfg.mode)
      SLF_MODE_DENSE: store = 1'b1;
      SLF_MODE_OUT:   store = below || above;
      SLF_MODE_CROSS: store = (new_zone != zone);
      SLF_MODE_IRQ1,
      SLF_MODE_IRQ2,
      SLF_MODE_IRQ12: store = irq_hit;
      default:        store = 1'b0; // reserved codes log nothing
    endcase
  end
  // word count of a record: ext words, battery word, tail
  wire [2:0] n_ext  = {2'h0, cfg.ext_en[0]} + {2'h0, cfg.ext_en[1]};
  wire [2:0] n_tail = is_limit ? 3'h1 : (is_dense ? 3'h0 : 3'h2);
  wire [2:0] n_rec  = n_ext + 3'h1 + n_tail;
  // dense temperature packing, msb first into a bit accumulator
  wire [31:0] acc_ins  = acc | ({i_meas.temp, 22'h0} >> nbits);
  wire [5:0]  pack_tot = {1'b0, nbits} + 6'h0A;
  wire        pack_out = pack_tot >= SLF_PACK_EMIT;
  // word selection during emission
  wire [2:0]  r_ext   = {2'h0, rec_cfg.ext_en[0]} + {2'h0, rec_cfg.ext_en[1]};
  wire        r_dense = (rec_cfg.mode == SLF_MODE_DENSE);
  wire        r_pack  = r_dense && !rec_cfg.batt_en && (rec_cfg.ext_en == 2'h0);
  wire        r_limit = (rec_cfg.mode == SLF_MODE_OUT) || (rec_cfg.mode == SLF_MODE_CROSS);
  wire        ext_tag = !r_dense;
  wire [15:0] w_external_sensor_one_input  = {ext_tag, rec.external_sensor_one_input_range, rec.external_sensor_one_input_val};
  wire [15:0] w_external_sensor_two_input  = {ext_tag, rec.external_sensor_two_input_range, rec.external_sensor_two_input_val};
  wire [15:0] w_bt    = {rec.batt, rec.temp};

  logic [15:0] word;
  always_comb begin
    if (r_pack) begin
      word = acc[31:16];
    end else if (idx < r_ext) begin
      word = ((idx == 3'h0) && rec_cfg.ext_en[0]) ? w_external_sensor_one_input : w_external_sensor_two_input;
    end else if (idx == r_ext) begin
      word = w_bt;
    end else if (r_limit) begin
      word = rec_num;
    end else if (idx == r_ext + 3'h1) begin
      word = rec.rtc[31:16];
    end else begin
      word = rec.rtc[15:0];
    end
  end

  // fifo between formatter and memory writer
  wire        f_in_valid = (state == SLF_EMIT);
  logic       f_in_ready;
  logic       f_out_valid;
  logic [15:0] f_out_data;
  logic [3:0] f_level;
  wire        out_take   = !o_word_valid || i_word_ready;
  wire        push       = f_in_valid && f_in_ready;
  wire        last       = push && (idx == nwords - 3'h1);

  slf_fifo #(
    .WIDTH (SLF_WORD_W),
    .DEPTH (SLF_FIFO_DEPTH)
  ) u_fifo (
    .i_mclk      (i_mclk),
    .i_nrst      (i_nrst),
    .i_in_valid  (f_in_valid),
    .i_in_data   (word),
    .o_in_ready  (f_in_ready),
    .o_out_valid (f_out_valid),
    .o_out_data  (f_out_data),
    .i_out_ready (out_take),
    .o_level     (f_level)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      SLF_IDLE: begin
        if (accept && (temp_only ? pack_out : store)) begin
          next_state = SLF_EMIT;
        end
      end
      SLF_EMIT: begin
        if (last) begin
          next_state = SLF_IDLE;
        end
      end
    endcase
  end

  // configuration registers; a config write restarts packing and crossing history
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      cfg    <= SLF_CFG_RST;
      lim_lo <= SLF_LIM_LO_RST;
      lim_hi <= SLF_LIM_HI_RST;
    end else begin
      if (cfg_wr) begin
        cfg <= i_wdata[SLF_CFG_W-1:0];
      end
      if (lo_wr) begin
        lim_lo <= i_wdata[SLF_LIM_W-1:0];
      end
      if (hi_wr) begin
        lim_hi <= i_wdata[SLF_LIM_W-1:0];
      end
    end
  end

  // interrupt pins: two-stage sync, then an edge register
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      irq_s1 <= 2'h0;
      irq_s2 <= 2'h0;
      irq_s3 <= 2'h0;
      pend   <= 2'h0;
    end else begin
      irq_s1 <= {i_external_sensor_two_input, i_external_sensor_one_input};
      irq_s2 <= irq_s1;
      irq_s3 <= irq_s2;
      // a new edge wins over the clear of the record that consumes it
      pend   <= ((accept && irq_hit) ? 2'h0 : pend) | (irq_rise & irq_mask);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      state        <= SLF_IDLE;
      o_meas_ready <= 1'b1;
      meas_cnt     <= 16'h0000;
      rec_num      <= 16'h0000;
      rec          <= '0;
      rec_cfg      <= SLF_CFG_RST;
      idx          <= 3'h0;
      nwords       <= 3'h0;
      acc          <= 32'h0000_0000;
      nbits        <= SLF_PACK_RST;
      zone         <= SLF_ZONE_IN;
    end else begin
      state        <= next_state;
      o_meas_ready <= (next_state == SLF_IDLE);
      if (accept) begin
        meas_cnt <= meas_cnt + 16'h0001;
        rec_num  <= meas_cnt;
        rec      <= i_meas;
        rec_cfg  <= cfg;
        idx      <= 3'h0;
        nwords   <= temp_only ? 3'h1 : n_rec;
        if (cfg.mode == SLF_MODE_CROSS) begin
          zone <= new_zone;
        end
        if (temp_only) begin
          acc   <= acc_ins;
          nbits <= pack_tot[4:0];
        end
      end else if (push) begin
        idx <= idx + 3'h1;
        if (r_pack) begin
          acc   <= {acc[15:0], 16'h0000};
          nbits <= nbits - 5'h10;
        end
      end
      if (cfg_wr) begin
        acc   <= 32'h0000_0000;
        nbits <= SLF_PACK_RST;
        zone  <= SLF_ZONE_IN;
      end
    end
  end

  // registered output stage so the writer sees flop outputs
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_word_valid <= 1'b0;
      o_word       <= 16'h0000;
    end else if (out_take) begin
      o_word_valid <= f_out_valid;
      o_word       <= f_out_data;
    end
  end

  // register reads: data only in the cycle after the strobe
  logic [31:0] rd_mux;
  always_comb begin
    unique case (i_addr)
      SLF_ADDR_CFG:    rd_mux = {24'h0, cfg};
      SLF_ADDR_LIM_LO: rd_mux = {22'h0, lim_lo};
      SLF_ADDR_LIM_HI: rd_mux = {22'h0, lim_hi};
      SLF_ADDR_STATUS: rd_mux = {9'h0, pend, (state == SLF_EMIT), f_level, meas_cnt};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
    end
  end
endmodule : slf_formatter

// ===== src/slf_pkg.sv
// shared constants and types for the sensor log record formatter
package slf_pkg;

  // register byte addresses
  localparam logic [7:0]  SLF_ADDR_CFG    = 8'h00;
  localparam logic [7:0]  SLF_ADDR_LIM_LO = 8'h04;
  localparam logic [7:0]  SLF_ADDR_LIM_HI = 8'h08;
  localparam logic [7:0]  SLF_ADDR_STATUS = 8'h0C;

  // config register layout: [7:6] ext enables, [5] battery, [4:3] limit sensor, [2:0] mode
  localparam int          SLF_CFG_W       = 8;
  localparam int          SLF_LIM_W       = 10;
  localparam logic [7:0]  SLF_CFG_RST     = 8'h00;
  localparam logic [9:0]  SLF_LIM_LO_RST  = 10'h000;
  localparam logic [9:0]  SLF_LIM_HI_RST  = 10'h3FF;

  // logging-mode codes
  localparam logic [2:0]  SLF_MODE_DENSE  = 3'h0;
  localparam logic [2:0]  SLF_MODE_OUT    = 3'h1;
  localparam logic [2:0]  SLF_MODE_RSV_A  = 3'h2;
  localparam logic [2:0]  SLF_MODE_CROSS  = 3'h3;
  localparam logic [2:0]  SLF_MODE_RSV_B  = 3'h4;
  localparam logic [2:0]  SLF_MODE_IRQ1   = 3'h5;
  localparam logic [2:0]  SLF_MODE_IRQ2   = 3'h6;
  localparam logic [2:0]  SLF_MODE_IRQ12  = 3'h7;

  // limit-check sensor codes
  localparam logic [1:0]  SLF_SEL_TEMP    = 2'h0;
  localparam logic [1:0]  SLF_SEL_EXTERNAL_SENSOR_ONE_INPUT    = 2'h1;
  localparam logic [1:0]  SLF_SEL_EXTERNAL_SENSOR_TWO_INPUT    = 2'h2;
  localparam logic [1:0]  SLF_SEL_BATT    = 2'h3;

  // crossing zones
  localparam logic [1:0]  SLF_ZONE_IN     = 2'h0;
  localparam logic [1:0]  SLF_ZONE_BELOW  = 2'h1;
  localparam logic [1:0]  SLF_ZONE_ABOVE  = 2'h2;

  localparam int          SLF_WORD_W      = 16;
  localparam int          SLF_FIFO_DEPTH  = 8;
  localparam logic [4:0]  SLF_PACK_RST    = 5'h00;
  localparam logic [5:0]  SLF_PACK_EMIT   = 6'h10;

  typedef struct packed {
    logic [1:0] ext_en;
    logic       batt_en;
    logic [1:0] limit_check_sensor_select;
    logic [2:0] mode;
  } slf_cfg_t;

  typedef struct packed {
    logic [9:0]  temp;
    logic [5:0]  batt;
    logic [4:0]  external_sensor_one_input_range;
    logic [9:0]  external_sensor_one_input_val;
    logic [4:0]  external_sensor_two_input_range;
    logic [9:0]  external_sensor_two_input_val;
    logic [31:0] rtc;
  } slf_sample_t;

  typedef enum logic {SLF_IDLE, SLF_EMIT} slf_state_t;

endpackage : slf_pkg

// ===== test/slf_mem_model.sv
// memory writer model that keeps the word stream in arrival order
module slf_mem_model (
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  input  wire logic [15:0] i_word,
  input  wire logic        i_valid,
  input  wire logic        i_hold,
  input  wire logic        i_slow,
  output logic             o_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:255];
  int          wp;
  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      wp <= 0;
      o_ready <= 1'b0;
    end else begin
      if (i_valid && o_ready) begin
        mem[wp[7:0]] <= i_word;  // index only, reader rebuilds times
        wp <= wp + 1;
      end
      o_ready <= !i_hold && !(i_slow && o_ready);
    end
  end
endmodule : slf_mem_model

// ===== test/slf_formatter_properties.sv
// port checker for the log record formatter
module slf_chk
  import slf_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_nrst,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire slf_sample_t i_meas,
  input wire logic        i_meas_valid,
  input wire logic        o_meas_ready,
  input wire logic [15:0] o_word,
  input wire logic        o_word_valid,
  input wire logic        i_word_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  cfg;
  logic [9:0]  lo;
  logic [9:0]  hi;
  wire         acc   = i_meas_valid && o_meas_ready;
  wire         lim1  = acc && cfg[4:0] == 5'h01;
  wire         out_t = i_meas.temp < lo || i_meas.temp > hi;
  wire  [15:0] bt    = {i_meas.batt, i_meas.temp};
  // shadow of the writable registers, fed from the bus alone
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      cfg <= SLF_CFG_RST;
      lo  <= SLF_LIM_LO_RST;
      hi  <= SLF_LIM_HI_RST;
    end else if (i_wr) begin
      if (i_addr == SLF_ADDR_CFG) cfg <= i_wdata[7:0];
      if (i_addr == SLF_ADDR_LIM_LO) lo <= i_wdata[9:0];
      if (i_addr == SLF_ADDR_LIM_HI) hi <= i_wdata[9:0];
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 32'h0) else $error("rdata not idle");
  AST_RD_CFG: assert property (
    i_rd && i_addr == SLF_ADDR_CFG |=> o_rdata == {24'h0, $past(cfg)})
    else $error("cfg readback wrong");
  AST_WORD_HOLD: assert property (
    o_word_valid && !i_word_ready |=> o_word_valid && $stable(o_word))
    else $error("word dropped");
  AST_RST_OUT: assert property (disable iff (1'b0) !i_nrst |=> !o_word_valid && o_meas_ready)
    else $error("reset outputs wrong");
  AST_DENSE_STORE: assert property (
    acc && cfg[2:0] == SLF_MODE_DENSE && cfg[5] |=> !o_meas_ready)
    else $error("dense sample not stored");
  AST_BATT_WORD: assert property (acc && cfg == 8'h20 && !o_word_valid && i_word_ready
    |=> ##2 o_word_valid && o_word == $past(bt, 3)) else $error("battery word wrong");
  AST_OUT_STORE: assert property (lim1 && out_t |=> !o_meas_ready) else $error("out not stored");
  AST_IN_SKIP: assert property (lim1 && !out_t |=> o_meas_ready) else $error("in-limit stored");
  cover property (acc && cfg[2:0] == SLF_MODE_CROSS);
  cover property (acc && cfg[2:0] == SLF_MODE_IRQ12);
  cover property (o_word_valid && !i_word_ready);
endmodule : slf_chk

bind slf_formatter slf_chk slf_chk_inst (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_meas(i_meas),
  .i_meas_valid(i_meas_valid), .o_meas_ready(o_meas_ready), .o_word(o_word),
  .o_word_valid(o_word_valid), .i_word_ready(i_word_ready));

// ===== test/tb_top.sv
// self-checking bench for the log record formatter
module tb_top
  import slf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, nrst, wr, rd, mv, p1, p2, hold, slow, mrdy, wv, wrdy;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, v;
  logic [15:0] word;
  logic [79:0] pk;
  slf_sample_t meas;
  int          num_errors = 0, n_checks = 0, cnt = 0, rp = 0;
  logic [15:0] exq[$];
  logic [7:0]  dc[3] = '{8'h20, 8'h40, 8'hA0};
  logic [7:0]  lc[3] = '{8'h01, 8'h03, 8'h19};
  logic [10:0] lt[3][6] = '{'{11'h450, 11'h150, 11'h601, 11'h200, 11'h4FF, 11'h100},
                           '{11'h150, 11'h450, 11'h060, 11'h650, 11'h580, 11'h180},
                           '{6{11'h550}}};
  slf_formatter slf_formatter_inst (.i_mclk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_meas(meas), .i_meas_valid(mv), .o_meas_ready(mrdy),
    .i_external_sensor_one_input(p1), .i_external_sensor_two_input(p2), .o_word(word),
    .o_word_valid(wv), .i_word_ready(wrdy));
  slf_mem_model slf_mem_model_inst (.i_mclk(clk), .i_nrst(nrst), .i_word(word), .i_valid(wv),
    .i_hold(hold), .i_slow(slow), .o_ready(wrdy));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // strobe drops two edges before the next task can raise it
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    {wr, rd} <= 2'b00;
    @(posedge clk);
    v = rdata;
  endtask : bus

  task send(input logic [9:0] t);
    @(posedge clk);
    meas <= '{temp: t, batt: 6'h2A, external_sensor_one_input_range: 5'h13, external_sensor_one_input_val: 10'h2C5, external_sensor_two_input_range: 5'h0E,
              external_sensor_two_input_val: 10'h1B3, rtc: {22'h2B1C4D, t}};
    mv <= 1'b1;
    @(posedge clk);
    while (mrdy !== 1'b1) @(posedge clk);
    mv <= 1'b0;
    cnt++;
  endtask : send

  task rec(input logic [1:0] en, input logic tg, input int tl);
    if (en[0]) exq.push_back({tg, meas.external_sensor_one_input_range, meas.external_sensor_one_input_val});
    if (en[1]) exq.push_back({tg, meas.external_sensor_two_input_range, meas.external_sensor_two_input_val});
    exq.push_back({meas.batt, meas.temp});
    if (tl == 1) exq.push_back(16'(cnt - 1));
    if (tl == 2) exq.push_back(meas.rtc[31:16]);
    if (tl == 2) exq.push_back(meas.rtc[15:0]);
  endtask : rec

  task pulse(input logic [1:0] m);
    @(posedge clk);
    {p2, p1} <= m;
    @(posedge clk);
    {p2, p1} <= 2'b00;
    repeat (4) @(posedge clk);
  endtask : pulse

  task drain();
    int i;
    i = 0;
    while (i < 8) begin
      @(posedge clk);
      i = (wv === 1'b0 && mrdy === 1'b1) ? i + 1 : 0;
    end
    while (exq.size() > 0) begin
      chk(slf_mem_model_inst.mem[rp], exq.pop_front());
      rp++;
    end
    chk(slf_mem_model_inst.wp, rp);
  endtask : drain

  task give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  initial begin
    nrst = 1'b0;
    {addr, wdata, meas, wr, rd, mv, p1, p2, hold, slow} = '0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, SLF_ADDR_LIM_HI, 32'h0);
    chk(v, 32'h3FF);
    bus(1'b1, 8'h40, 32'hFF);
    bus(1'b1, SLF_ADDR_STATUS, 32'hFFFF);
    bus(1'b0, SLF_ADDR_CFG, 32'h0);
    chk(v, 32'h0);
    bus(1'b0, 8'h40, 32'h0);
    chk(v, 32'h0);
    for (int i = 0; i < 8; i++) begin
      send(10'h3A5 ^ 10'(i * 93));
      pk = {pk[69:0], meas.temp};
    end
    for (int j = 0; j < 5; j++) exq.push_back(pk[79 - 16 * j -: 16]);
    drain();
    foreach (dc[k]) begin
      bus(1'b1, SLF_ADDR_CFG, {24'h0, dc[k]});
      for (int j = 0; j < 2; j++) begin
        send(10'h155 + 10'(cnt));
        rec(dc[k][7:6], 1'b0, 0);
      end
      drain();
    end
    // full fifo with the writer stalled must hold the formatter off
    bus(1'b1, SLF_ADDR_CFG, 32'hE0);
    hold <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      send(10'h0F0 + 10'(cnt));
      rec(2'b11, 1'b0, 0);
    end
    repeat (6) @(posedge clk);
    chk(mrdy, 1'b0);
    bus(1'b0, SLF_ADDR_STATUS, 32'h0);
    chk(v[19:16], 4'h8);
    hold <= 1'b0;
    drain();
    bus(1'b1, SLF_ADDR_LIM_LO, 32'h100);
    bus(1'b1, SLF_ADDR_LIM_HI, 32'h200);
    slow <= 1'b1;
    foreach (lc[k]) begin
      bus(1'b1, SLF_ADDR_CFG, {24'h0, lc[k]});
      for (int j = 0; j < 6; j++) begin
        send(lt[k][j][9:0]);
        if (lt[k][j][10]) rec(2'b00, 1'b1, 1);
      end
      drain();
    end
    slow <= 1'b0;
    for (int m = 5; m < 8; m++) begin
      bus(1'b1, SLF_ADDR_CFG, 32'(8'hC0 | m));
      pulse(~m[1:0]);
      send(10'h3FF);
      pulse(m[1:0]);
      send(10'h3FF - 10'(m));
      rec(2'b11, 1'b1, 2);
    end
    drain();
    bus(1'b0, SLF_ADDR_STATUS, 32'h0);
    chk(v[15:0], cnt[15:0]);
    give_verdict();
  end
endmodule : tb_top
